// ==== sam_monitor.sv ====
// Servo alarm monitor: detects faults, latches an alarm code, drives servo enable.
// Assumes all detector flags arrive from outside and are synchronised here;
// position, speed and command buses come from same-clock logic.
`timescale 1ns/10ps

// Functional notes
// - Motor overvoltage gives code 1, servo off
// - Control over/undervoltage gives code 2/3, off
// - Parameter out of range gives 11, off
// - Move while servo off gives 21, off
// - Move before/while homing gives 22, on
// - Homing timeout gives 23, servo off
// - Write during mode-1 jog gives 24, on
// - Bad table/relative/press sign gives 25, on
// - Overspeed gives 31, servo stays on
// - Deviation over limit gives 32, off
// - Alternate stop defers deviation to next move
// - Soft limit passed gives 33, on
// - Pressing pushed back gives 34, off
// - Startup memory check fail gives 51, off
// - No feedback or blocked start gives 52
// - Encoder lost gives 53, servo off
// - No progress two seconds gives 54, off
// - Power stage overheat gives 55, off
// - Emergency halt gives 63, off
// - Only 22,24,25,31,33 keep servo energised
module sam_monitor #(
	parameter int STALL_CYC = sam_pkg::SAM_STALL_CYC, // Stall window in cycles
	parameter int POS_W = 32 // Position width
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Asynchronous detector flags
	input wire logic mot_ov_i,
	input wire logic ctl_ov_i,
	input wire logic ctl_uv_i,
	input wire logic param_bad_i,
	input wire logic nvm_bad_i,
	input wire logic nvm_done_i,
	input wire logic no_feedback_i,
	input wire logic start_blocked_i,
	input wire logic enc_lost_i,
	input wire logic overheat_i,
	input wire logic emergency_halt_i,
	input wire logic press_pushback_i,
	// Host command strobes (same clock)
	input wire logic move_cmd_i,
	input wire logic move_is_pos_i,
	input wire logic move_rel_i,
	input wire logic home_return_i,
	input wire logic home_done_i,
	input wire logic program_write_strobe_i,
	input wire logic jog_active_i,
	input wire logic [2:0] op_mode_i,
	input wire logic table_empty_i,
	input wire logic press_sign_bad_i,
	input wire logic servo_on_req_i,
	// Motion feedback (same clock)
	input wire logic signed [POS_W-1:0] cmd_pos_i,
	input wire logic signed [POS_W-1:0] act_pos_i,
	input wire logic [31:0] speed_i,
	input wire logic at_target_i,
	// Outputs
	output logic servo_energise_o,
	output logic [7:0] alarm_code_o,
	output logic alarm_o
);
	import sam_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NSYNC = 12;
	logic [NSYNC-1:0] async_in; // Raw flags
	logic [NSYNC-1:0] sync1_r; // First stage, read only by second
	logic [NSYNC-1:0] sync2_r; // Safe copies
	assign async_in = {press_pushback_i, emergency_halt_i, overheat_i, enc_lost_i,
		start_blocked_i, no_feedback_i, nvm_done_i, nvm_bad_i, param_bad_i,
		ctl_uv_i, ctl_ov_i, mot_ov_i};

	// Two flop synchroniser
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= async_in;
			sync2_r <= sync1_r;
		end
	end

	logic s_mot_ov, s_ctl_ov, s_ctl_uv, s_param, s_nvm_bad, s_nvm_done;
	logic s_nofb, s_blocked, s_enc, s_heat, s_halt, s_push;
	assign {s_push, s_halt, s_heat, s_enc, s_blocked, s_nofb, s_nvm_done, s_nvm_bad,
		s_param, s_ctl_uv, s_ctl_ov, s_mot_ov} = sync2_r;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] devlim_r; // Deviation limit
	logic [31:0] hometo_r; // Homing timeout in ticks
	logic signed [31:0] softlo_r; // Lower soft limit
	logic signed [31:0] softhi_r; // Upper soft limit
	logic [31:0] maxspd_r; // Maximum speed
	logic [1:0] stop_mode_r; // Stop mode, nonzero = alternate
	logic clr_pulse; // Software clear of the alarm latch
	logic [7:0] code_r; // Latched alarm code
	logic servo_r; // Servo energised
	logic homed_r; // Homing complete
	logic homing_r; // Homing in progress
	logic dev_pend_r; // Deferred deviation pending

	assign clr_pulse = reg_wr_i && reg_addr_i == SAM_REG_CTRL && reg_wdata_i[SAM_CTRL_CLR_BIT];

	// Register writes
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			devlim_r <= SAM_DEVLIM_RST;
			hometo_r <= SAM_HOMETO_RST;
			softlo_r <= SAM_SOFTLO_RST;
			softhi_r <= SAM_SOFTHI_RST;
			maxspd_r <= SAM_MAXSPD_RST;
			stop_mode_r <= SAM_STOP_NORMAL;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				SAM_REG_CTRL: stop_mode_r <= reg_wdata_i[SAM_CTRL_STOP_MSB:SAM_CTRL_STOP_LSB];
				SAM_REG_DEVLIM: devlim_r <= reg_wdata_i;
				SAM_REG_HOMETO: hometo_r <= reg_wdata_i;
				SAM_REG_SOFTLO: softlo_r <= reg_wdata_i;
				SAM_REG_SOFTHI: softhi_r <= reg_wdata_i;
				SAM_REG_MAXSPD: maxspd_r <= reg_wdata_i;
				default: ; // Others ignored
			endcase
		end
	end

	// Read data, one cycle later, unmapped reads zero
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				SAM_REG_CODE: reg_rdata_o <= {24'h00_0000, code_r};
				SAM_REG_CTRL: reg_rdata_o <= {29'h0000_0000, stop_mode_r, 1'b0};
				SAM_REG_STAT: reg_rdata_o <= {28'h000_0000, dev_pend_r, homing_r, homed_r, servo_r};
				SAM_REG_DEVLIM: reg_rdata_o <= devlim_r;
				SAM_REG_HOMETO: reg_rdata_o <= hometo_r;
				SAM_REG_SOFTLO: reg_rdata_o <= softlo_r;
				SAM_REG_SOFTHI: reg_rdata_o <= softhi_r;
				SAM_REG_MAXSPD: reg_rdata_o <= maxspd_r;
				default: reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end

	// ----------------------------------------
	// Homing tracking and timeout
	// ----------------------------------------
	logic [7:0] tick_cnt_r; // Microsecond prescaler
	logic [31:0] home_cnt_r; // Homing elapsed ticks
	logic home_to; // Timeout event

	// Homing state
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			homed_r <= 1'b0;
			homing_r <= 1'b0;
		end else if (home_done_i && homing_r) begin
			homed_r <= 1'b1;
			homing_r <= 1'b0;
		end else if (home_return_i && servo_r) begin
			homed_r <= 1'b0;
			homing_r <= 1'b1;
		end else if (home_to || !servo_r) begin
			homing_r <= 1'b0;
		end
	end

	// Tick prescaler and timeout counter
	always_ff @(posedge mclk_i) begin
		if (rst_i || !homing_r) begin
			tick_cnt_r <= '0;
			home_cnt_r <= '0;
		end else if (tick_cnt_r == 8'(SAM_HOME_TICK_CYC - 1)) begin
			tick_cnt_r <= '0;
			home_cnt_r <= home_cnt_r + 32'h0000_0001;
		end else begin
			tick_cnt_r <= tick_cnt_r + 8'h01;
		end
	end
	assign home_to = homing_r && home_cnt_r >= hometo_r;

	// ----------------------------------------
	// Stall watchdog
	// ----------------------------------------
	logic moving_r; // Move accepted, target not reached
	logic [31:0] stall_cnt_r; // Cycles without progress
	logic signed [POS_W-1:0] last_pos_r; // Position at last check
	logic stall; // Stall event

	// Stall counter, reset on any position change
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			moving_r <= 1'b0;
			stall_cnt_r <= '0;
			last_pos_r <= '0;
		end else begin
			last_pos_r <= act_pos_i;
			if (stall) begin
				// Stall ends the move even if a new command lands now
				moving_r <= 1'b0;
				stall_cnt_r <= '0;
			end else if (move_cmd_i && servo_r) begin
				moving_r <= 1'b1;
				stall_cnt_r <= '0;
			end else if (at_target_i || !servo_r) begin
				moving_r <= 1'b0;
				stall_cnt_r <= '0;
			end else if (moving_r) begin
				stall_cnt_r <= (act_pos_i != last_pos_r) ? '0 : stall_cnt_r + 32'h0000_0001;
			end
		end
	end
	assign stall = moving_r && stall_cnt_r >= 32'(STALL_CYC - 1);

	// ----------------------------------------
	// Deviation and limits
	// ----------------------------------------
	logic signed [POS_W:0] dev_diff; // Signed position error
	logic [POS_W:0] dev_abs; // Magnitude
	logic dev_over; // Limit exceeded
	assign dev_diff = {cmd_pos_i[POS_W-1], cmd_pos_i} - {act_pos_i[POS_W-1], act_pos_i};
	assign dev_abs = dev_diff[POS_W] ? (POS_W+1)'(-dev_diff) : dev_diff;
	assign dev_over = dev_abs > (POS_W+1)'(devlim_r);

	// Deferred deviation, raised by the next move when stop mode is alternate
	// A new excess beats a same-cycle clear so it is never lost
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			dev_pend_r <= 1'b0;
		end else if (dev_over && stop_mode_r != SAM_STOP_NORMAL) begin
			dev_pend_r <= 1'b1;
		end else if (move_cmd_i || clr_pulse) begin
			dev_pend_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Startup check
	// ----------------------------------------
	logic start_r; // Before first servo-on attempt completes

	// Startup window for memory check and initial servo-on
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			start_r <= 1'b1;
		end else if (servo_r) begin
			start_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Alarm priority encoder
	// ----------------------------------------
	logic [7:0] code_nxt; // Highest priority event this cycle
	logic mv_bad_home; // Move conflicts with homing

	assign mv_bad_home = move_cmd_i && ((move_is_pos_i && !homed_r) || homing_r);

	// Off-alarms take priority over keep-on alarms
	always_comb begin
		code_nxt = SAM_ALM_NONE;
		if (s_halt) code_nxt = SAM_ALM_HALT;
		else if (s_mot_ov) code_nxt = SAM_ALM_MOT_OV;
		else if (s_ctl_ov) code_nxt = SAM_ALM_CTL_OV;
		else if (s_ctl_uv) code_nxt = SAM_ALM_CTL_UV;
		else if (s_heat) code_nxt = SAM_ALM_OVERHEAT;
		else if (s_enc) code_nxt = SAM_ALM_ENC_LOST;
		else if (s_nvm_done && s_nvm_bad && start_r) code_nxt = SAM_ALM_NVM;
		else if (s_nofb || (s_blocked && start_r)) code_nxt = SAM_ALM_DETECT;
		else if (s_param) code_nxt = SAM_ALM_PARAM;
		else if (move_cmd_i && !servo_r) code_nxt = SAM_ALM_MV_SVOFF;
		else if (home_to) code_nxt = SAM_ALM_HOME_TO;
		else if (dev_over && stop_mode_r == SAM_STOP_NORMAL) code_nxt = SAM_ALM_DEVIATION;
		else if (dev_pend_r && move_cmd_i) code_nxt = SAM_ALM_DEVIATION;
		else if (s_push && servo_r) code_nxt = SAM_ALM_PRESS;
		else if (stall) code_nxt = SAM_ALM_STALL;
		else if (mv_bad_home) code_nxt = SAM_ALM_MV_HOME;
		else if (program_write_strobe_i && jog_active_i && op_mode_i == SAM_MODE_JOG)
			code_nxt = SAM_ALM_WR_MOVE;
		else if (move_cmd_i && (table_empty_i || press_sign_bad_i
			|| (op_mode_i == SAM_MODE_ABS && move_rel_i)))
			code_nxt = SAM_ALM_POS_DATA;
		else if (speed_i > maxspd_r) code_nxt = SAM_ALM_SPEED;
		else if (act_pos_i < softlo_r || act_pos_i > softhi_r) code_nxt = SAM_ALM_SOFT_LIM;
	end

	// Codes that leave the servo energised
	function automatic logic keeps_on(input logic [7:0] c);
		keeps_on = c == SAM_ALM_MV_HOME || c == SAM_ALM_WR_MOVE || c == SAM_ALM_POS_DATA
			|| c == SAM_ALM_SPEED || c == SAM_ALM_SOFT_LIM;
	endfunction

	logic alarm_r; // Alarm flag, kept in step with the code

	// Latch: new event wins over a same-cycle clear
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			code_r <= SAM_ALM_NONE;
			alarm_r <= 1'b0;
		end else if (code_nxt != SAM_ALM_NONE) begin
			code_r <= code_nxt;
			alarm_r <= 1'b1;
		end else if (clr_pulse) begin
			code_r <= SAM_ALM_NONE;
			alarm_r <= 1'b0;
		end
	end

	// Servo enable: off on any off-alarm, blocked while an off-alarm is latched
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			servo_r <= 1'b0;
		end else if (code_nxt != SAM_ALM_NONE && !keeps_on(code_nxt)) begin
			servo_r <= 1'b0;
		end else if (code_r != SAM_ALM_NONE && !keeps_on(code_r)) begin
			servo_r <= 1'b0;
		end else begin
			servo_r <= servo_on_req_i;
		end
	end

	assign servo_energise_o = servo_r;
	assign alarm_code_o = code_r;
	assign alarm_o = alarm_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_halt_code;
		@(posedge mclk_i) disable iff (rst_i) s_halt |=> code_r == SAM_ALM_HALT;
	endproperty
	a_halt_code: assert property (p_halt_code) else $error("halt not coded 63");

	property p_halt_off;
		@(posedge mclk_i) disable iff (rst_i) s_halt |=> !servo_r;
	endproperty
	a_halt_off: assert property (p_halt_off) else $error("servo on after halt");

	property p_mot_ov;
		@(posedge mclk_i) disable iff (rst_i) s_mot_ov && !s_halt |=> code_r == SAM_ALM_MOT_OV;
	endproperty
	a_mot_ov: assert property (p_mot_ov) else $error("motor overvolt not 1");

	property p_svoff_move;
		@(posedge mclk_i) disable iff (rst_i)
			move_cmd_i && !servo_r && !s_halt && !s_mot_ov && !s_ctl_ov && !s_ctl_uv && !s_heat
			&& !s_enc && !(s_nvm_done && s_nvm_bad && start_r) && !s_nofb
			&& !(s_blocked && start_r) && !s_param |=> code_r == SAM_ALM_MV_SVOFF ##1 !servo_r;
	endproperty
	a_svoff_move: assert property (p_svoff_move) else $error("move at servo off missed");

	property p_keep_on;
		@(posedge mclk_i) disable iff (rst_i)
			servo_r && code_r == SAM_ALM_NONE && code_nxt == SAM_ALM_SPEED && servo_on_req_i
			|=> servo_r;
	endproperty
	a_keep_on: assert property (p_keep_on) else $error("overspeed dropped servo");

	property p_off_hold;
		@(posedge mclk_i) disable iff (rst_i)
			code_r == SAM_ALM_ENC_LOST && !clr_pulse |=> code_r != SAM_ALM_NONE;
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("latch lost code");

	property p_clear;
		@(posedge mclk_i) disable iff (rst_i) clr_pulse && code_nxt == SAM_ALM_NONE |=> !alarm_o;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");

	property p_defer;
		@(posedge mclk_i) disable iff (rst_i)
			dev_over && stop_mode_r != SAM_STOP_NORMAL && !move_cmd_i
			&& code_r != SAM_ALM_DEVIATION |=> code_r != SAM_ALM_DEVIATION && dev_pend_r;
	endproperty
	a_defer: assert property (p_defer) else $error("deviation not deferred");

	property p_stall;
		@(posedge mclk_i) disable iff (rst_i) stall |=> !moving_r;
	endproperty
	a_stall: assert property (p_stall) else $error("stall not ended");

	c_halt: cover property (@(posedge mclk_i) disable iff (rst_i) s_halt ##1 !servo_r);
	c_soft: cover property (@(posedge mclk_i) disable iff (rst_i) code_r == SAM_ALM_SOFT_LIM && servo_r);
	c_home_to: cover property (@(posedge mclk_i) disable iff (rst_i) home_to);
	c_defer: cover property (@(posedge mclk_i) disable iff (rst_i) dev_pend_r ##1 move_cmd_i);
endmodule // sam_monitor

// ==== sam_pkg.sv ====
// Package for the servo alarm monitor: alarm codes, register map, timing.
// Assumes a single 250 MHz system clock and a plain strobe register port.
package sam_pkg;
	// ----------------------------------------
	// Alarm codes
	// ----------------------------------------
	localparam logic [7:0] SAM_ALM_NONE = 8'h00;
	localparam logic [7:0] SAM_ALM_MOT_OV = 8'h01;
	localparam logic [7:0] SAM_ALM_CTL_OV = 8'h02;
	localparam logic [7:0] SAM_ALM_CTL_UV = 8'h03;
	localparam logic [7:0] SAM_ALM_PARAM = 8'h0B;
	localparam logic [7:0] SAM_ALM_MV_SVOFF = 8'h15;
	localparam logic [7:0] SAM_ALM_MV_HOME = 8'h16;
	localparam logic [7:0] SAM_ALM_HOME_TO = 8'h17;
	localparam logic [7:0] SAM_ALM_WR_MOVE = 8'h18;
	localparam logic [7:0] SAM_ALM_POS_DATA = 8'h19;
	localparam logic [7:0] SAM_ALM_SPEED = 8'h1F;
	localparam logic [7:0] SAM_ALM_DEVIATION = 8'h20;
	localparam logic [7:0] SAM_ALM_SOFT_LIM = 8'h21;
	localparam logic [7:0] SAM_ALM_PRESS = 8'h22;
	localparam logic [7:0] SAM_ALM_NVM = 8'h33;
	localparam logic [7:0] SAM_ALM_DETECT = 8'h34;
	localparam logic [7:0] SAM_ALM_ENC_LOST = 8'h35;
	localparam logic [7:0] SAM_ALM_STALL = 8'h36;
	localparam logic [7:0] SAM_ALM_OVERHEAT = 8'h37;
	localparam logic [7:0] SAM_ALM_HALT = 8'h3F;
	// ----------------------------------------
	// Operating modes and stop modes
	// ----------------------------------------
	localparam logic [2:0] SAM_MODE_JOG = 3'h1;
	localparam logic [2:0] SAM_MODE_ABS = 3'h5;
	localparam logic [1:0] SAM_STOP_NORMAL = 2'h0;
	// ----------------------------------------
	// Register map (word addresses)
	// ----------------------------------------
	localparam logic [3:0] SAM_REG_CODE = 4'h0;
	localparam logic [3:0] SAM_REG_CTRL = 4'h1;
	localparam logic [3:0] SAM_REG_STAT = 4'h2;
	localparam logic [3:0] SAM_REG_DEVLIM = 4'h3;
	localparam logic [3:0] SAM_REG_HOMETO = 4'h4;
	localparam logic [3:0] SAM_REG_SOFTLO = 4'h5;
	localparam logic [3:0] SAM_REG_SOFTHI = 4'h6;
	localparam logic [3:0] SAM_REG_MAXSPD = 4'h7;
	localparam logic [1:0] SAM_CTRL_CLR_BIT = 2'd0;
	localparam logic [1:0] SAM_CTRL_STOP_LSB = 2'd1;
	localparam logic [1:0] SAM_CTRL_STOP_MSB = 2'd2;
	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [31:0] SAM_DEVLIM_RST = 32'h0000_1000;
	localparam logic [31:0] SAM_HOMETO_RST = 32'h0000_FFFF;
	localparam logic [31:0] SAM_SOFTLO_RST = 32'h8000_0000;
	localparam logic [31:0] SAM_SOFTHI_RST = 32'h7FFF_FFFF;
	localparam logic [31:0] SAM_MAXSPD_RST = 32'h0001_0000;
	localparam int SAM_CLK_MHZ = 250;
	localparam int SAM_STALL_MS = 2000;
	localparam int SAM_STALL_CYC = SAM_STALL_MS * 1000 * SAM_CLK_MHZ;
	localparam int SAM_HOME_TICK_CYC = 250;
endpackage : sam_pkg

// ==== sam_host_model.sv ====
// Host controller model: issues move, homing, jog and program-write commands.
// Assumes the bench calls its tasks from one process, clocked by mclk_i.
`timescale 1ns/10ps
module sam_host_model (
	// Clock
	input wire logic mclk_i,
	// Command lines
	output logic move_cmd_o,
	output logic move_is_pos_o,
	output logic move_rel_o,
	output logic home_return_o,
	output logic home_done_o,
	output logic program_write_strobe_o,
	output logic jog_active_o,
	output logic [2:0] op_mode_o,
	output logic table_empty_o,
	output logic press_sign_bad_o,
	output logic servo_on_req_o
);
	// ----------------------------------------
	// Idle state at time zero
	// ----------------------------------------
	initial begin
		move_cmd_o = 1'b0;
		move_is_pos_o = 1'b0;
		move_rel_o = 1'b0;
		home_return_o = 1'b0;
		home_done_o = 1'b0;
		program_write_strobe_o = 1'b0;
		jog_active_o = 1'b0;
		op_mode_o = 3'h0;
		table_empty_o = 1'b0;
		press_sign_bad_o = 1'b0;
		servo_on_req_o = 1'b0;
	end
	// One-cycle move with its qualifiers, released together
	task automatic move(input logic pos, input logic rel, input logic emp, input logic psb);
		@(posedge mclk_i);
		move_cmd_o <= 1'b1;
		move_is_pos_o <= pos;
		move_rel_o <= rel;
		table_empty_o <= emp;
		press_sign_bad_o <= psb;
		@(posedge mclk_i);
		move_cmd_o <= 1'b0;
		move_is_pos_o <= 1'b0;
		move_rel_o <= 1'b0;
		table_empty_o <= 1'b0;
		press_sign_bad_o <= 1'b0;
	endtask
	// One-cycle strobe: 0 homing start, 1 homing done, 2 program write
	task automatic pulse(input int k);
		@(posedge mclk_i);
		home_return_o <= (k == 0);
		home_done_o <= (k == 1);
		program_write_strobe_o <= (k == 2);
		@(posedge mclk_i);
		home_return_o <= 1'b0;
		home_done_o <= 1'b0;
		program_write_strobe_o <= 1'b0;
	endtask
	// Levels: jog motion, operating mode, servo request
	task automatic set_mode(input logic jog, input logic [2:0] mode, input logic on);
		@(posedge mclk_i);
		jog_active_o <= jog;
		op_mode_o <= mode;
		servo_on_req_o <= on;
	endtask
endmodule // sam_host_model

// ==== sam_monitor_tb_top.sv ====
// Bench for the servo alarm monitor: register tasks and scripted fault scenarios.
// Assumes the host model drives commands; the bench drives flags, feedback, registers.
`timescale 1ns/10ps
module sam_monitor_tb_top;
	import sam_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int STALL_T = 50; // Shortened stall window
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [8:0] flg = 9'h000; // Detector flags, one bit each
	logic nvm_bad_i = 1'b0;
	logic nvm_done_i = 1'b0;
	logic start_blocked_i = 1'b0;
	logic move_cmd_i, move_is_pos_i, move_rel_i, home_return_i, home_done_i;
	logic program_write_strobe_i, jog_active_i, table_empty_i, press_sign_bad_i, servo_on_req_i;
	logic [2:0] op_mode_i;
	logic signed [31:0] cmd_pos_i = 32'h0000_0000;
	logic signed [31:0] act_pos_i = 32'h0000_0000;
	logic [31:0] speed_i = 32'h0000_0000;
	logic at_target_i = 1'b1;
	logic servo_energise_o, alarm_o;
	logic [7:0] alarm_code_o;
	logic [1:0] stop_sel = 2'h0; // Stop mode kept on every control write
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [7:0] fcode [9] = '{SAM_ALM_MOT_OV, SAM_ALM_CTL_OV, SAM_ALM_CTL_UV, SAM_ALM_PARAM,
		SAM_ALM_DETECT, SAM_ALM_ENC_LOST, SAM_ALM_OVERHEAT, SAM_ALM_HALT, SAM_ALM_PRESS};
	logic [3:0] ra [8] = '{4'h0, 4'h2, SAM_REG_DEVLIM, SAM_REG_HOMETO, SAM_REG_SOFTLO,
		SAM_REG_SOFTHI, SAM_REG_MAXSPD, 4'hF};
	logic [31:0] rv [8] = '{32'h0000_0000, 32'h0000_0000, SAM_DEVLIM_RST, SAM_HOMETO_RST,
		SAM_SOFTLO_RST, SAM_SOFTHI_RST, SAM_MAXSPD_RST, 32'h0000_0000};
	// ----------------------------------------
	// Design and host model
	// ----------------------------------------
	sam_monitor #(.STALL_CYC(STALL_T), .POS_W(32)) i_dut (.mclk_i, .rst_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mot_ov_i(flg[0]), .ctl_ov_i(flg[1]),
		.ctl_uv_i(flg[2]), .param_bad_i(flg[3]), .nvm_bad_i, .nvm_done_i, .no_feedback_i(flg[4]),
		.start_blocked_i, .enc_lost_i(flg[5]), .overheat_i(flg[6]), .emergency_halt_i(flg[7]),
		.press_pushback_i(flg[8]), .move_cmd_i, .move_is_pos_i, .move_rel_i, .home_return_i,
		.home_done_i, .program_write_strobe_i, .jog_active_i, .op_mode_i, .table_empty_i,
		.press_sign_bad_i, .servo_on_req_i, .cmd_pos_i, .act_pos_i, .speed_i, .at_target_i,
		.servo_energise_o, .alarm_code_o, .alarm_o);
	sam_host_model i_host (.mclk_i, .move_cmd_o(move_cmd_i), .move_is_pos_o(move_is_pos_i),
		.move_rel_o(move_rel_i), .home_return_o(home_return_i), .home_done_o(home_done_i),
		.program_write_strobe_o(program_write_strobe_i), .jog_active_o(jog_active_i),
		.op_mode_o(op_mode_i), .table_empty_o(table_empty_i),
		.press_sign_bad_o(press_sign_bad_i), .servo_on_req_o(servo_on_req_i));
	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Read strobe, then data checked in the following cycle
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		cmp_count++;
		if (reg_rdata_o !== exp) begin
			err_total++;
			$display("ERROR t=%0t read %0h got %h exp %h", $time, a, reg_rdata_o, exp);
		end
	endtask
	// Let flags pass the synchronisers, then compare code, alarm and servo
	task automatic chk(input logic [7:0] code, input logic srv);
		repeat (6) @(posedge mclk_i);
		#1;
		cmp_count++;
		if (alarm_code_o !== code || servo_energise_o !== srv || alarm_o !== (code != 8'h00)) begin
			err_total++;
			$display("ERROR t=%0t code %0d servo %b exp %0d %b", $time, alarm_code_o,
				servo_energise_o, code, srv);
		end
	endtask
	// Let dropped flags leave the synchronisers, clear the latch, expect idle
	task automatic clr();
		repeat (3) @(posedge mclk_i);
		wr(SAM_REG_CTRL, {29'h0, stop_sel, 1'b1});
		chk(SAM_ALM_NONE, servo_on_req_i);
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
		// Start window faults, servo still off
		start_blocked_i <= 1'b1;
		chk(SAM_ALM_DETECT, 1'b0);
		start_blocked_i <= 1'b0;
		clr();
		nvm_bad_i <= 1'b1;
		nvm_done_i <= 1'b1;
		chk(SAM_ALM_NVM, 1'b0);
		nvm_bad_i <= 1'b0;
		clr();
		i_host.move(1'b0, 1'b0, 1'b0, 1'b0);
		chk(SAM_ALM_MV_SVOFF, 1'b0);
		clr();
		i_host.set_mode(1'b0, 3'h0, 1'b1);
		chk(SAM_ALM_NONE, 1'b1);
		// Each of the nine flg detector flags, latched after it drops
		for (int i = 0; i < 9; i++) begin
			flg <= 9'h001 << i;
			chk(fcode[i], 1'b0);
			flg <= 9'h000;
			chk(fcode[i], 1'b0);
			clr();
		end
		flg <= 9'h081;
		chk(SAM_ALM_HALT, 1'b0);
		flg <= 9'h000;
		clr();
		// Servo-on alarms
		i_host.move(1'b1, 1'b0, 1'b0, 1'b0);
		chk(SAM_ALM_MV_HOME, 1'b1);
		clr();
		i_host.set_mode(1'b1, SAM_MODE_JOG, 1'b1);
		i_host.pulse(2);
		chk(SAM_ALM_WR_MOVE, 1'b1);
		clr();
		for (int k = 0; k < 3; k++) begin
			i_host.set_mode(1'b0, (k == 1) ? SAM_MODE_ABS : 3'h0, 1'b1);
			i_host.move(1'b0, k == 1, k == 0, k == 2);
			chk(SAM_ALM_POS_DATA, 1'b1);
			clr();
		end
		i_host.set_mode(1'b0, 3'h0, 1'b1);
		speed_i <= SAM_MAXSPD_RST + 32'h0000_0001;
		chk(SAM_ALM_SPEED, 1'b1);
		speed_i <= SAM_MAXSPD_RST;
		clr();
		wr(SAM_REG_SOFTHI, 32'h0000_0100);
		cmd_pos_i <= 32'h0000_0101;
		act_pos_i <= 32'h0000_0101;
		chk(SAM_ALM_SOFT_LIM, 1'b1);
		cmd_pos_i <= 32'h0000_0000;
		act_pos_i <= 32'h0000_0000;
		wr(SAM_REG_SOFTHI, SAM_SOFTHI_RST);
		clr();
		// Deviation, immediate then deferred
		cmd_pos_i <= SAM_DEVLIM_RST + 32'h0000_0001;
		chk(SAM_ALM_DEVIATION, 1'b0);
		cmd_pos_i <= 32'h0000_0000;
		clr();
		stop_sel = 2'h1;
		wr(SAM_REG_CTRL, 32'h0000_0002);
		rd(SAM_REG_CTRL, 32'h0000_0002);
		cmd_pos_i <= SAM_DEVLIM_RST + 32'h0000_0001;
		chk(SAM_ALM_NONE, 1'b1);
		cmd_pos_i <= 32'h0000_0000;
		rd(SAM_REG_STAT, 32'h0000_0009);
		i_host.move(1'b0, 1'b0, 1'b0, 1'b0);
		chk(SAM_ALM_DEVIATION, 1'b0);
		stop_sel = 2'h0;
		clr();
		// Homing: move while homing, timeout, then success
		wr(SAM_REG_HOMETO, 32'h0000_0002);
		i_host.pulse(0);
		i_host.move(1'b0, 1'b0, 1'b0, 1'b0);
		chk(SAM_ALM_MV_HOME, 1'b1);
		clr();
		for (int n = 0; n < 1000 && alarm_code_o !== SAM_ALM_HOME_TO; n++) @(posedge mclk_i);
		chk(SAM_ALM_HOME_TO, 1'b0);
		clr();
		i_host.pulse(0);
		i_host.pulse(1);
		i_host.move(1'b1, 1'b0, 1'b0, 1'b0);
		chk(SAM_ALM_NONE, 1'b1);
		rd(SAM_REG_STAT, 32'h0000_0003);
		// Stall: quiet before the window, alarm after it
		at_target_i <= 1'b0;
		i_host.move(1'b1, 1'b0, 1'b0, 1'b0);
		repeat (STALL_T - 20) @(posedge mclk_i);
		chk(SAM_ALM_NONE, 1'b1);
		for (int n = 0; n < 200 && alarm_code_o !== SAM_ALM_STALL; n++) @(posedge mclk_i);
		chk(SAM_ALM_STALL, 1'b0);
		at_target_i <= 1'b1;
		clr();
		finish_test();
	end
endmodule // sam_monitor_tb_top
